// >>> logic/tcn_dev_end.sv
// Controller end: decodes nine-track function words, packs words and frames, builds status.
// Assumes the tape side reports frames, blanks, check frames and errors as one-cycle strobes.
// Notes on behaviour
// - Skip/Write write phase packs like Write.
// - Host forms Skip Only as code 773.
// - Even parity marks Skip Only; never auxiliary.
// - Data word starts motion and erase.
// - Erase done: drop word, status, interrupt.
// - Skip Only acts as stopped seven-track Skip/Write.
// - Bits 17..9 decode as octal function codes.
// - Bootstrap code zero means word 400000000.
// - Frame count not multiple of 15: bit 17.
// - Forward EOF frame plus two blanks: bit 16.
// - Forward end-of-file also sets parity error.
// - Backward EOF frame seven to nine from check.
// - End-of-file also sets abnormal frame count.
// - Forward parity: lateral, longitudinal, diagonal mismatch.
// - Write parity: lateral or longitudinal errors.
// - Missing diagonal frame on end-of-file no error.
// - Backward parity ignores diagonal check.
// - Function bit 4 set means invalid.
// - Auxiliary unit rejects write-type functions.
// - Track format mismatch with unit: invalid.
// - Bootstrap switch mismatch with unit zero: invalid.
// - Forward bad track number in bits 8..5.
// - Bits 3..0 frame count mod 15 if taken.
// - Four words map onto fifteen frames.
`timescale 1ns/10ps
`default_nettype none
module tcn_dev_end (
	input wire logic sys_clk,
	input wire logic rst_n,
	tcn_chan_if.dev chan,
	input wire logic aux_unit,
	input wire logic unit_nine,
	input wire logic track_format_select_switch,
	input wire logic unit0_nine,
	input wire logic tp_frame_valid,
	input wire logic [8:0] tp_frame,
	input wire logic tp_blank,
	input wire logic tp_lcf,
	input wire logic tp_diag,
	input wire logic tp_lat_err,
	input wire logic tp_long_err,
	input wire logic tp_diag_err,
	input wire logic [3:0] tp_bad_track,
	input wire logic tp_block_end,
	input wire logic tp_erase_done,
	input wire logic tp_wr_ready,
	output logic tp_wr_valid_q,
	output logic [7:0] tp_wr_frame_q,
	output logic tp_wr_end_q,
	output logic tp_fwd_q,
	output logic tp_bwd_q,
	output logic tp_erase_q,
	output logic tp_rewind_q,
	output logic [3:0] tp_unit_q
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_START = 6'h02,
		ST_READ = 6'h04,
		ST_WRITE = 6'h08,
		ST_ERASE = 6'h10,
		ST_REPORT = 6'h20
	} tcn_state_t;

	tcn_state_t state_q;
	tcn_state_t state_d;
	logic [29:0] fn_q;
	logic [37:0] acc_q;
	logic [5:0] cnt_q;
	logic [3:0] fc_q;
	logic [1:0] dcnt_q;
	logic fe_arm_q;
	logic [1:0] fe_bl_q;
	logic fe_eof_q;
	logic [3:0] pos_q;
	logic bk_hit_q;
	logic par_q;
	logic [3:0] bt_q;
	logic end_q;
	logic blk_q;
	logic sent_q;
	logic taken_q;
	logic out_ready_q;
	logic in_valid_q;
	logic [29:0] in_word_q;
	logic in_last_q;
	logic sts_valid_q;
	logic [17:0] sts_word_q;
	logic ext_int_q;
	logic [17:0] sts_w;

	// Function code fields of the held word.
	// The code-zero bootstrap word would otherwise decode as a file mark write.
	wire [2:0] fcode = fn_q[tcn_pkg::FN_CODE_HI:tcn_pkg::FN_CODE_LO];
	wire boot_zero = fn_q == tcn_pkg::BOOT_WORD;
	wire is_rdfw = fcode == tcn_pkg::CODE_RDFW;
	wire is_rdbk = fcode == tcn_pkg::CODE_RDBK;
	wire is_boot = fcode == tcn_pkg::CODE_BOOT | boot_zero;
	wire is_weof = fcode == tcn_pkg::CODE_WEOF & ~boot_zero;
	wire is_skip = fcode == tcn_pkg::CODE_SKIP;
	wire is_skonly = is_skip & fn_q[tcn_pkg::FN_EVEN];
	wire is_wrty = fcode == tcn_pkg::CODE_WRITE | is_skip | is_weof;
	wire is_rew = fcode == tcn_pkg::CODE_RWI | fcode == tcn_pkg::CODE_RWL;
	wire fwdboot = is_rdfw | is_boot;
	wire is_read = fwdboot | is_rdbk;
	wire fmt_bad = (is_read & ~is_boot | is_wrty) & (fn_q[tcn_pkg::FN_NINE] != unit_nine);
	wire inv = fn_q[tcn_pkg::FN_BAD]
		| aux_unit & is_wrty
		| fmt_bad
		| is_boot & (track_format_select_switch != unit0_nine);

	// Datapath strobes; a word leaves the read side before a new frame is merged.
	wire rd_mode = state_q == ST_READ;
	wire wr_mode = state_q == ST_WRITE;
	wire rd_frm = rd_mode & tp_frame_valid & ~blk_q;
	wire rd_pop = rd_mode & ~in_valid_q & (cnt_q >= tcn_pkg::WORD_BITS | blk_q & cnt_q != 6'h00);
	wire in_take = in_valid_q & chan.in_ready;
	wire wr_room = wr_mode & ~end_q & cnt_q < tcn_pkg::FRAME_BITS;
	wire er_room = state_q == ST_ERASE & ~tp_erase_q;
	wire out_take = chan.out_valid & out_ready_q;
	wire wr_take = out_take & wr_mode;
	wire er_take = out_take & state_q == ST_ERASE;
	wire wr_emit = wr_mode & (~tp_wr_valid_q | tp_wr_ready)
		& (cnt_q >= tcn_pkg::FRAME_BITS | end_q & cnt_q != 6'h00);
	wire wr_fin = wr_mode & end_q & cnt_q == 6'h00 & ~tp_wr_valid_q & ~sent_q;
	wire [5:0] sh_n = rd_pop ? tcn_pkg::WORD_BITS : (wr_emit ? tcn_pkg::FRAME_BITS : 6'h00);
	wire [37:0] acc_s = acc_q << sh_n;
	wire [5:0] cnt_s = (cnt_q > sh_n) ? cnt_q - sh_n : 6'h00;
	wire [37:0] add_v = rd_frm ? {tp_frame[7:0], 30'h0} : (wr_take ? {chan.out_word, 8'h00} : 38'h0);
	wire [5:0] add_n = rd_frm ? tcn_pkg::FRAME_BITS : (wr_take ? tcn_pkg::WORD_BITS : 6'h00);
	wire [37:0] acc_d = tcn_pkg::tcn_merge(acc_s, add_v, cnt_s);
	wire [5:0] cnt_d = cnt_s + add_n;
	wire is_eof_frm = tp_frame[8:0] == tcn_pkg::EOF_FRAME;
	wire pos_ev = tp_frame_valid | tp_blank | tp_diag;
	wire [3:0] pos_n = (pos_q == 4'hF) ? pos_q : pos_q + 4'h1;
	wire run = rd_mode | wr_mode;
	wire err_ev = tp_lat_err | tp_long_err | tp_diag_err & fwdboot & rd_mode;
	wire rd_done = rd_mode & blk_q & cnt_q == 6'h00 & ~in_valid_q;
	wire wr_done = wr_mode & sent_q & blk_q;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (chan.fn_valid) state_d = ST_START;
			ST_START:
				if (inv | is_rew) state_d = ST_REPORT;
				else if (is_read) state_d = ST_READ;
				else if (is_skonly) state_d = ST_ERASE;
				else state_d = ST_WRITE;
			ST_READ: if (rd_done) state_d = ST_REPORT;
			ST_WRITE: if (wr_done) state_d = ST_REPORT;
			ST_ERASE: if (tp_erase_q & tp_erase_done) state_d = ST_REPORT;
			default: state_d = ST_IDLE;
		endcase
	end

	// Status word; an invalid function reports nothing else.
	wire fe_eof = fwdboot & fe_eof_q;
	wire bk_eof = is_rdbk & bk_hit_q & dcnt_q == 2'h1;
	wire eof = fe_eof | bk_eof;
	always_comb
	begin
		sts_w = 18'h00000;
		if (inv)
			sts_w[tcn_pkg::ST_INV] = 1'b1;
		else if (~is_rew)
		begin
			sts_w[tcn_pkg::ST_AFC] = is_read & (fc_q != 4'h0 | eof);
			sts_w[tcn_pkg::ST_EOF] = eof;
			sts_w[tcn_pkg::ST_PAR] = par_q | fe_eof;
			if (fwdboot & (par_q | fe_eof))
				sts_w[tcn_pkg::ST_BT_HI:tcn_pkg::ST_BT_LO] = bt_q;
			if (is_read & taken_q)
				sts_w[tcn_pkg::ST_FC_HI:0] = fc_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			fn_q <= 30'h0;
			acc_q <= 38'h0;
			cnt_q <= 6'h00;
		end
		else
		begin
			state_q <= state_d;
			if (state_q == ST_IDLE & chan.fn_valid)
				fn_q <= chan.fn_word;
			acc_q <= (state_q == ST_START) ? 38'h0 : acc_d;
			cnt_q <= (state_q == ST_START) ? 6'h00 : cnt_d;
		end
	end

	// Block tracking: frame count, end-of-file patterns, errors.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fc_q <= 4'h0;
			dcnt_q <= 2'h0;
			fe_arm_q <= 1'b0;
			fe_bl_q <= 2'h0;
			fe_eof_q <= 1'b0;
			pos_q <= 4'h0;
			bk_hit_q <= 1'b0;
			par_q <= 1'b0;
			bt_q <= 4'h0;
		end
		else if (state_q == ST_START)
		begin
			fc_q <= 4'h0;
			dcnt_q <= 2'h0;
			fe_arm_q <= 1'b0;
			fe_bl_q <= 2'h0;
			fe_eof_q <= 1'b0;
			pos_q <= 4'h0;
			bk_hit_q <= 1'b0;
			par_q <= 1'b0;
			bt_q <= 4'h0;
		end
		else
		begin
			if (rd_frm)
			begin
				fc_q <= (fc_q == tcn_pkg::FC_LAST) ? 4'h0 : fc_q + 4'h1;
				dcnt_q <= (dcnt_q == 2'h2) ? dcnt_q : dcnt_q + 2'h1;
				fe_arm_q <= dcnt_q == 2'h0 & is_eof_frm;
				fe_bl_q <= 2'h0;
				if (is_eof_frm & pos_n >= tcn_pkg::BK_EOF_MIN & pos_n <= tcn_pkg::BK_EOF_MAX)
					bk_hit_q <= 1'b1;
			end
			else if (rd_mode & tp_blank & fe_arm_q)
			begin
				fe_bl_q <= fe_bl_q + 2'h1;
				if (fe_bl_q + 2'h1 == tcn_pkg::FWD_EOF_BLANKS)
					fe_eof_q <= 1'b1;
			end
			if (rd_mode & tp_lcf)
				pos_q <= 4'h0;
			else if (rd_mode & pos_ev)
				pos_q <= pos_n;
			if (run & err_ev)
				par_q <= 1'b1;
			if (rd_mode & fwdboot & tp_bad_track != 4'h0)
				bt_q <= tp_bad_track;
		end
	end

	// Channel side handshakes and tape control.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			end_q <= 1'b0;
			blk_q <= 1'b0;
			sent_q <= 1'b0;
			taken_q <= 1'b0;
			out_ready_q <= 1'b0;
			in_valid_q <= 1'b0;
			in_word_q <= 30'h0;
			in_last_q <= 1'b0;
			tp_wr_valid_q <= 1'b0;
			tp_wr_frame_q <= 8'h00;
			tp_wr_end_q <= 1'b0;
			tp_fwd_q <= 1'b0;
			tp_bwd_q <= 1'b0;
			tp_erase_q <= 1'b0;
			tp_rewind_q <= 1'b0;
			tp_unit_q <= 4'h0;
			sts_valid_q <= 1'b0;
			sts_word_q <= 18'h00000;
			ext_int_q <= 1'b0;
		end
		else
		begin
			end_q <= (state_q == ST_START) ? is_weof : end_q | wr_take & chan.out_last;
			blk_q <= (state_q != ST_START) & (blk_q | run & tp_block_end);
			sent_q <= (state_q != ST_START) & (sent_q | wr_fin);
			taken_q <= (state_q != ST_START) & (taken_q | in_take & in_last_q);
			out_ready_q <= (wr_room | er_room) & ~out_take;
			if (rd_pop)
			begin
				in_valid_q <= 1'b1;
				in_word_q <= acc_q[37:8];
				in_last_q <= blk_q & cnt_q <= tcn_pkg::WORD_BITS;
			end
			else if (in_take | chan.in_stop)
				in_valid_q <= 1'b0;
			if (wr_emit)
			begin
				tp_wr_valid_q <= 1'b1;
				tp_wr_frame_q <= acc_q[37:30];
			end
			else if (tp_wr_ready)
				tp_wr_valid_q <= 1'b0;
			tp_wr_end_q <= wr_fin;
			if (state_q == ST_START)
			begin
				tp_unit_q <= fn_q[tcn_pkg::FN_UNIT_HI:0];
				tp_fwd_q <= ~inv & (fwdboot | is_weof);
				tp_bwd_q <= ~inv & is_rdbk;
			end
			else if (state_q == ST_REPORT)
			begin
				tp_fwd_q <= 1'b0;
				tp_bwd_q <= 1'b0;
			end
			else if (wr_take | er_take)
				tp_fwd_q <= 1'b1;
			tp_erase_q <= (state_q == ST_ERASE) & (tp_erase_q | er_take);
			tp_rewind_q <= state_q == ST_START & ~inv & is_rew;
			sts_valid_q <= state_q == ST_REPORT;
			ext_int_q <= state_q == ST_REPORT;
			if (state_q == ST_REPORT)
				sts_word_q <= sts_w;
		end
	end

	assign chan.out_ready = out_ready_q;
	assign chan.in_valid = in_valid_q;
	assign chan.in_word = in_word_q;
	assign chan.in_last = in_last_q;
	assign chan.sts_valid = sts_valid_q;
	assign chan.sts_word = sts_word_q;
	assign chan.ext_int = ext_int_q;
endmodule
`default_nettype wire

// >>> logic/tcn_pkg.sv
// Shared constants for the nine-track function decoder and status builder.
// Assumes 30-bit channel words and 9-bit tape frames (8 data bits plus parity).
package tcn_pkg;
	localparam int WORD_W = 30;
	localparam int STS_W = 18;
	localparam int ACC_W = 38;
	localparam logic [2:0] CODE_WEOF = 3'h0;
	localparam logic [2:0] CODE_RDBK = 3'h1;
	localparam logic [2:0] CODE_RWI = 3'h2;
	localparam logic [2:0] CODE_RWL = 3'h3;
	localparam logic [2:0] CODE_BOOT = 3'h4;
	localparam logic [2:0] CODE_WRITE = 3'h5;
	localparam logic [2:0] CODE_RDFW = 3'h6;
	localparam logic [2:0] CODE_SKIP = 3'h7;
	localparam int FN_CODE_HI = 17;
	localparam int FN_CODE_LO = 15;
	localparam int FN_EVEN = 14;
	localparam int FN_DENS_HI = 13;
	localparam int FN_DENS_LO = 12;
	localparam int FN_NINE = 10;
	localparam int FN_LOWG = 9;
	localparam int FN_BAD = 4;
	localparam int FN_UNIT_HI = 3;
	localparam logic [1:0] DENS_800 = 2'h3;
	localparam logic [29:0] BOOT_WORD = 30'h4000000;
	localparam int ST_AFC = 17;
	localparam int ST_EOF = 16;
	localparam int ST_PAR = 12;
	localparam int ST_INV = 9;
	localparam int ST_BT_HI = 8;
	localparam int ST_BT_LO = 5;
	localparam int ST_FC_HI = 3;
	localparam logic [8:0] EOF_FRAME = 9'h013;
	localparam logic [3:0] FC_LAST = 4'hE;
	localparam logic [3:0] BK_EOF_MIN = 4'h7;
	localparam logic [3:0] BK_EOF_MAX = 4'h9;
	localparam logic [1:0] FWD_EOF_BLANKS = 2'h2;
	localparam logic [5:0] WORD_BITS = 6'h1E;
	localparam logic [5:0] FRAME_BITS = 6'h08;

	// Ors a left-aligned bit group in just below the bits already held.
	function automatic logic [ACC_W-1:0] tcn_merge(input logic [ACC_W-1:0] acc,
		input logic [ACC_W-1:0] val, input logic [5:0] cnt);
		tcn_merge = acc | (val >> cnt);
	endfunction
endpackage

// >>> logic/tcn_chan_if.sv
// Processor channel between the tape controller and its host.
// Assumes both ends share sys_clk; all signals change after its rising edge.
`timescale 1ns/10ps
`default_nettype none
interface tcn_chan_if;
	logic fn_valid;
	logic [29:0] fn_word;
	logic out_valid;
	logic [29:0] out_word;
	logic out_last;
	logic out_ready;
	logic in_valid;
	logic [29:0] in_word;
	logic in_last;
	logic in_ready;
	logic in_stop;
	logic sts_valid;
	logic [17:0] sts_word;
	logic ext_int;
	modport dev (input fn_valid, input fn_word, input out_valid, input out_word,
		input out_last, output out_ready, output in_valid, output in_word,
		output in_last, input in_ready, input in_stop, output sts_valid,
		output sts_word, output ext_int);
	modport host (output fn_valid, output fn_word, output out_valid, output out_word,
		output out_last, input out_ready, input in_valid, input in_word,
		input in_last, output in_ready, output in_stop, input sts_valid,
		input sts_word, input ext_int);
endinterface
`default_nettype wire

// >>> logic/tcn_host_end.sv
// Processor end: forms function words, forwards output words, returns input and status.
// Assumes one outstanding function at a time; the user waits for status before the next.
`timescale 1ns/10ps
`default_nettype none
module tcn_host_end (
	input wire logic sys_clk,
	input wire logic rst_n,
	tcn_chan_if.host chan,
	input wire logic usr_req_valid,
	input wire logic [2:0] usr_op,
	input wire logic usr_skip_only,
	input wire logic usr_low_gain,
	input wire logic usr_d800,
	input wire logic usr_nine,
	input wire logic [3:0] usr_unit,
	input wire logic usr_boot_zero,
	input wire logic usr_to_aux,
	input wire logic usr_wr_valid,
	input wire logic [29:0] usr_wr_word,
	input wire logic usr_wr_last,
	output logic usr_wr_ready_q,
	input wire logic usr_rd_hold,
	output logic usr_rd_valid_q,
	output logic [29:0] usr_rd_word_q,
	output logic usr_rd_last_q,
	output logic usr_sts_valid_q,
	output logic [17:0] usr_sts_q,
	output logic usr_irq_q,
	output logic usr_refused_q,
	output logic usr_busy_q
);
	logic fn_valid_q;
	logic [29:0] fn_word_q;
	logic out_valid_q;
	logic [29:0] out_word_q;
	logic out_last_q;
	logic in_ready_q;
	logic in_stop_q;
	logic [29:0] fw;

	// Skip Only is forced to its one legal form; Skip Only aimed at an auxiliary target is refused.
	wire refuse = usr_skip_only & usr_to_aux;
	wire req_take = usr_req_valid & ~usr_busy_q & ~refuse;
	wire usr_take = usr_wr_valid & usr_wr_ready_q;
	wire out_valid_d = usr_take | out_valid_q & ~chan.out_ready;

	always_comb
	begin
		fw = 30'h0;
		if (usr_skip_only)
		begin
			fw[tcn_pkg::FN_CODE_HI:tcn_pkg::FN_CODE_LO] = tcn_pkg::CODE_SKIP;
			fw[tcn_pkg::FN_EVEN] = 1'b1;
			fw[tcn_pkg::FN_DENS_HI:tcn_pkg::FN_DENS_LO] = tcn_pkg::DENS_800;
			fw[tcn_pkg::FN_NINE] = 1'b1;
			fw[tcn_pkg::FN_LOWG] = 1'b1;
		end
		else if (usr_op == tcn_pkg::CODE_BOOT & usr_boot_zero)
			fw = tcn_pkg::BOOT_WORD;
		else
		begin
			fw[tcn_pkg::FN_CODE_HI:tcn_pkg::FN_CODE_LO] = usr_op;
			if (usr_op != tcn_pkg::CODE_BOOT & usr_op != tcn_pkg::CODE_RWI
				& usr_op != tcn_pkg::CODE_RWL)
			begin
				fw[tcn_pkg::FN_DENS_HI:tcn_pkg::FN_DENS_LO] = usr_d800 ? tcn_pkg::DENS_800 : 2'h0;
				fw[tcn_pkg::FN_NINE] = usr_nine;
				fw[tcn_pkg::FN_LOWG] = usr_low_gain;
			end
		end
		if (~(usr_op == tcn_pkg::CODE_BOOT & usr_boot_zero) | usr_skip_only)
			fw[tcn_pkg::FN_UNIT_HI:0] = usr_unit;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fn_valid_q <= 1'b0;
			fn_word_q <= 30'h0;
			out_valid_q <= 1'b0;
			out_word_q <= 30'h0;
			out_last_q <= 1'b0;
			in_ready_q <= 1'b0;
			in_stop_q <= 1'b0;
			usr_wr_ready_q <= 1'b0;
			usr_rd_valid_q <= 1'b0;
			usr_rd_word_q <= 30'h0;
			usr_rd_last_q <= 1'b0;
			usr_sts_valid_q <= 1'b0;
			usr_sts_q <= 18'h00000;
			usr_irq_q <= 1'b0;
			usr_refused_q <= 1'b0;
			usr_busy_q <= 1'b0;
		end
		else
		begin
			fn_valid_q <= req_take;
			if (req_take)
				fn_word_q <= fw;
			usr_refused_q <= usr_req_valid & ~usr_busy_q & refuse;
			usr_busy_q <= (usr_busy_q | req_take) & ~chan.sts_valid;
			out_valid_q <= out_valid_d;
			if (usr_take)
			begin
				out_word_q <= usr_wr_word;
				out_last_q <= usr_wr_last;
			end
			// Ready only while the single slot will be empty, so no word is overwritten.
			usr_wr_ready_q <= usr_busy_q & ~chan.sts_valid & ~out_valid_d;
			in_ready_q <= usr_busy_q & ~usr_rd_hold;
			in_stop_q <= usr_busy_q & usr_rd_hold & chan.in_valid & ~in_stop_q;
			usr_rd_valid_q <= chan.in_valid & in_ready_q;
			usr_rd_word_q <= chan.in_word;
			usr_rd_last_q <= chan.in_last;
			usr_sts_valid_q <= chan.sts_valid;
			if (chan.sts_valid)
				usr_sts_q <= chan.sts_word;
			usr_irq_q <= chan.ext_int;
		end
	end

	assign chan.fn_valid = fn_valid_q;
	assign chan.fn_word = fn_word_q;
	assign chan.out_valid = out_valid_q;
	assign chan.out_word = out_word_q;
	assign chan.out_last = out_last_q;
	assign chan.in_ready = in_ready_q;
	assign chan.in_stop = in_stop_q;
endmodule
`default_nettype wire

// >>> verif/tcn_chan_sva.sv
// Concurrent checks on the channel between the host end and the controller end.
// Assumes the testbench instantiates it beside the interface that joins both ends.
`timescale 1ns/10ps
`default_nettype none
module tcn_chan_sva (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic fn_valid,
	input wire logic [29:0] fn_word,
	input wire logic sts_valid,
	input wire logic [17:0] sts_word,
	input wire logic ext_int
);
	logic [2:0] op_q;
	wire is_boot = fn_word == tcn_pkg::BOOT_WORD;
	wire is_fwd = op_q == tcn_pkg::CODE_RDFW || op_q == tcn_pkg::CODE_BOOT;
	wire is_rd = is_fwd || op_q == tcn_pkg::CODE_RDBK;

	// The code-zero bootstrap word must not be taken for a file mark write.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			op_q <= 3'h0;
		else if (fn_valid)
			op_q <= is_boot ? tcn_pkg::CODE_BOOT : fn_word[17:15];
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_fn_zero;
		fn_valid && fn_word[17:9] == 9'h000;
	endsequence
	sequence s_skip_only;
		fn_valid && fn_word[17:15] == 3'h7 && fn_word[14];
	endsequence
	sequence s_report;
		sts_valid && ext_int ##1 !sts_valid && !ext_int;
	endsequence

	property p_boot_word;
		s_fn_zero |-> is_boot;
	endproperty
	a_boot_word: assert property (p_boot_word)
		else $error("code zero function word is not the bootstrap word");
	property p_skip_code;
		s_skip_only |-> fn_word[17:9] == 9'h1FB;
	endproperty
	a_skip_code: assert property (p_skip_code)
		else $error("even parity skip word has a wrong code");
	property p_int;
		sts_valid |-> s_report;
	endproperty
	a_int: assert property (p_int)
		else $error("status without a one cycle interrupt");
	property p_int_src;
		ext_int |-> sts_valid;
	endproperty
	a_int_src: assert property (p_int_src)
		else $error("interrupt without status");
	property p_eof_afc;
		sts_valid && sts_word[16] |-> sts_word[17];
	endproperty
	a_eof_afc: assert property (p_eof_afc)
		else $error("end of file without abnormal count");
	property p_eof_par;
		sts_valid && is_fwd && sts_word[16] |-> sts_word[12];
	endproperty
	a_eof_par: assert property (p_eof_par)
		else $error("forward end of file without parity error");
	property p_bt_zero;
		sts_valid && !(is_fwd && sts_word[12]) |-> sts_word[8:5] == 4'h0;
	endproperty
	a_bt_zero: assert property (p_bt_zero)
		else $error("bad track field not zero");
	property p_fc_zero;
		sts_valid && !is_rd |-> sts_word[3:0] == 4'h0;
	endproperty
	a_fc_zero: assert property (p_fc_zero)
		else $error("frame count field set outside reads");
	property p_afc_mod;
		sts_valid && is_rd && sts_word[3:0] != 4'h0 |-> sts_word[17];
	endproperty
	a_afc_mod: assert property (p_afc_mod)
		else $error("partial frame group without abnormal count");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Bench: host end and controller end joined over the channel; a second controller
// faces the bench directly. Assumes one clock; the bench plays user and tape side.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic aux = 1'b0, unit_nine = 1'b1, fsw = 1'b1, u0_nine = 1'b1, wrdy = 1'b1;
	logic req = 1'b0, so = 1'b0, boot0 = 1'b0, wv = 1'b0, wl = 1'b0;
	logic [2:0] op = 3'h0;
	logic [29:0] ww = 30'h0;
	logic [8:0] frame = 9'h000;
	logic [8:0] ev = 9'h000;
	logic [3:0] bad = 4'h0;
	logic wr_rdy, rd_v, sv, refused, tp_wv, tp_end, fwd, bwd, erase;
	logic [29:0] rd_w;
	logic [17:0] sts;
	logic [7:0] tp_f;
	logic [7:0] wf[4] = '{8'hA1, 8'hB2, 8'hC3, 8'h54};
	logic [29:0] rd_q[$];
	logic [7:0] fr_q[$];
	int num_errors = 0, checked = 0, cyc = 0;
	tcn_chan_if chan ();
	tcn_chan_if chan2 ();
	wire [6:0] sel = {chan2.sts_valid, refused, sv, tp_end, erase, bwd, fwd};

	always #5 sys_clk = ~sys_clk;

	tcn_host_end tcn_host_end_i (.sys_clk(sys_clk), .rst_n(rst_n), .chan(chan.host),
		.usr_req_valid(req), .usr_op(op), .usr_skip_only(so), .usr_low_gain(1'b1),
		.usr_d800(1'b1), .usr_nine(1'b1), .usr_unit(4'h1), .usr_boot_zero(boot0),
		.usr_to_aux(aux), .usr_wr_valid(wv), .usr_wr_word(ww), .usr_wr_last(wl),
		.usr_wr_ready_q(wr_rdy), .usr_rd_hold(1'b0), .usr_rd_valid_q(rd_v),
		.usr_rd_word_q(rd_w), .usr_rd_last_q(), .usr_sts_valid_q(sv), .usr_sts_q(sts),
		.usr_irq_q(), .usr_refused_q(refused), .usr_busy_q());
	tcn_dev_end tcn_dev_end_i (.sys_clk(sys_clk), .rst_n(rst_n), .chan(chan.dev),
		.aux_unit(aux), .unit_nine(unit_nine), .track_format_select_switch(fsw),
		.unit0_nine(u0_nine), .tp_frame_valid(ev[0]), .tp_frame(frame), .tp_blank(ev[1]),
		.tp_lcf(ev[2]), .tp_diag(ev[3]), .tp_lat_err(ev[4]), .tp_long_err(ev[5]),
		.tp_diag_err(ev[6]), .tp_bad_track(bad), .tp_block_end(ev[7]),
		.tp_erase_done(ev[8]), .tp_wr_ready(wrdy), .tp_wr_valid_q(tp_wv),
		.tp_wr_frame_q(tp_f), .tp_wr_end_q(tp_end), .tp_fwd_q(fwd), .tp_bwd_q(bwd),
		.tp_erase_q(erase), .tp_rewind_q(), .tp_unit_q());
	tcn_dev_end tcn_dev_end_i2 (.sys_clk(sys_clk), .rst_n(rst_n), .chan(chan2.dev),
		.aux_unit(aux), .unit_nine(unit_nine), .track_format_select_switch(fsw),
		.unit0_nine(u0_nine), .tp_frame_valid(ev[0]), .tp_frame(frame), .tp_blank(ev[1]),
		.tp_lcf(ev[2]), .tp_diag(ev[3]), .tp_lat_err(ev[4]), .tp_long_err(ev[5]),
		.tp_diag_err(ev[6]), .tp_bad_track(bad), .tp_block_end(ev[7]),
		.tp_erase_done(ev[8]), .tp_wr_ready(wrdy), .tp_wr_valid_q(), .tp_wr_frame_q(),
		.tp_wr_end_q(), .tp_fwd_q(), .tp_bwd_q(), .tp_erase_q(), .tp_rewind_q(),
		.tp_unit_q());
	tcn_chan_sva tcn_chan_sva_i (.sys_clk(sys_clk), .rst_n(rst_n), .fn_valid(chan.fn_valid),
		.fn_word(chan.fn_word), .sts_valid(chan.sts_valid), .sts_word(chan.sts_word),
		.ext_int(chan.ext_int));

	task automatic cmp(input logic [29:0] seen, input logic [29:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic clk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// A gap cycle after each strobe keeps one assignment per signal per time step.
	task automatic pulse(input logic [8:0] m);
		ev <= m;
		@(posedge sys_clk);
		ev <= 9'h000;
		@(posedge sys_clk);
	endtask
	task automatic tape(input logic [8:0] f);
		frame <= f;
		pulse(9'h001);
	endtask
	task automatic wait_hi(input logic [6:0] m);
		int n = 0;
		while ((sel & m) == 7'h00 && n < 300)
		begin
			n++;
			@(posedge sys_clk);
		end
		if (n == 300)
			num_errors++;
	endtask
	task automatic cmd(input logic [2:0] o, input logic s, input logic b);
		op <= o;
		so <= s;
		boot0 <= b;
		req <= 1'b1;
		@(posedge sys_clk);
		req <= 1'b0;
	endtask
	task automatic put(input logic [29:0] w);
		int n = 0;
		ww <= w;
		wl <= 1'b1;
		wv <= 1'b1;
		@(posedge sys_clk);
		while (wr_rdy !== 1'b1 && n < 300)
		begin
			n++;
			@(posedge sys_clk);
		end
		if (n == 300)
			num_errors++;
		wv <= 1'b0;
	endtask
	task automatic status(input logic [17:0] exp);
		wait_hi(7'h10);
		cmp(30'(sts), 30'(exp));
		clk(2);
	endtask

	always @(posedge sys_clk)
	begin
		if (tp_wv && wrdy)
			fr_q.push_back(tp_f);
		if (rd_v)
			rd_q.push_back(rd_w);
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			close_out();
		end
	end

	initial
	begin
		chan2.fn_valid = 1'b0;
		chan2.fn_word = 30'h0;
		chan2.out_valid = 1'b0;
		chan2.out_word = 30'h0;
		chan2.out_last = 1'b0;
		chan2.in_ready = 1'b1;
		chan2.in_stop = 1'b0;
		clk(4);
		rst_n <= 1'b1;
		clk(2);
		chan2.fn_word <= 30'h00033611;
		chan2.fn_valid <= 1'b1;
		@(posedge sys_clk);
		chan2.fn_valid <= 1'b0;
		wait_hi(7'h40);
		cmp(30'(chan2.sts_word), 30'h200);
		clk(2);
		// A refused final word leaves the frame count field empty.
		chan2.fn_word <= 30'h00033601;
		chan2.in_ready <= 1'b0;
		chan2.fn_valid <= 1'b1;
		@(posedge sys_clk);
		chan2.fn_valid <= 1'b0;
		clk(3);
		tape(9'h0AA);
		pulse(9'h080);
		clk(2);
		chan2.in_stop <= 1'b1;
		@(posedge sys_clk);
		chan2.in_stop <= 1'b0;
		wait_hi(7'h40);
		cmp(30'(chan2.sts_word), 30'h20000);
		clk(2);
		for (int k = 0; k < 2; k++)
		begin
			fr_q.delete();
			cmd(k == 0 ? tcn_pkg::CODE_WRITE : tcn_pkg::CODE_SKIP, 1'b0, 1'b0);
			put(30'h286CB0D5);
			wait_hi(7'h08);
			pulse(k == 0 ? 9'h010 : 9'h020);
			pulse(9'h080);
			status(18'h01000);
			for (int i = 0; i < 4; i++)
				cmp(30'(fr_q[i]), 30'(wf[i]));
		end
		cmd(tcn_pkg::CODE_WEOF, 1'b0, 1'b0);
		wait_hi(7'h08);
		pulse(9'h040);
		pulse(9'h080);
		status(18'h00000);
		fr_q.delete();
		cmd(tcn_pkg::CODE_SKIP, 1'b1, 1'b0);
		put(30'h3FFFFFFF);
		wait_hi(7'h04);
		cmp(30'(fwd), 30'h1);
		pulse(9'h100);
		status(18'h00000);
		cmp(30'(fr_q.size()), 30'h0);
		cmd(tcn_pkg::CODE_RDFW, 1'b0, 1'b0);
		wait_hi(7'h01);
		tape(9'h013);
		pulse(9'h002);
		pulse(9'h002);
		pulse(9'h080);
		status(18'h31001);
		cmp(rd_q.pop_front(), 30'h04C00000);
		bad <= 4'h5;
		cmd(tcn_pkg::CODE_RDFW, 1'b0, 1'b0);
		wait_hi(7'h01);
		tape(9'h0AA);
		pulse(9'h010);
		tape(9'h055);
		pulse(9'h080);
		status(18'h210A2);
		cmp(rd_q.pop_front(), 30'h2A954000);
		bad <= 4'h0;
		cmd(tcn_pkg::CODE_RDBK, 1'b0, 1'b0);
		wait_hi(7'h02);
		pulse(9'h004);
		repeat (6) pulse(9'h002);
		pulse(9'h008);
		pulse(9'h040);
		tape(9'h013);
		pulse(9'h080);
		status(18'h30001);
		for (int k = 0; k < 3; k++)
		begin
			unit_nine <= k != 0;
			aux <= k == 1;
			u0_nine <= k != 2;
			cmd(k == 0 ? tcn_pkg::CODE_RDFW : k == 1 ? tcn_pkg::CODE_WRITE : tcn_pkg::CODE_BOOT,
				1'b0, k == 2);
			status(18'h00200);
		end
		unit_nine <= 1'b1;
		u0_nine <= 1'b1;
		aux <= 1'b1;
		cmd(tcn_pkg::CODE_SKIP, 1'b1, 1'b0);
		wait_hi(7'h20);
		cmp(30'(refused), 30'h1);
		clk(5);
		close_out();
	end
endmodule
`default_nettype wire
